// file: core/dswcfg_decoder.sv
// Switch configuration decoder top: samples three switch banks after reset,
// decodes clocking, loop, rate and sampling settings, and adopts the rate
// set by the far-end unit in plug-and-play mode.
// Assumes switch and loop-request pins are asynchronous, far-end rate
// messages arrive on tx_clk, and sys_rst marks power-up.
//
// Overview of operation
// [RL1] Installer keeps first bank all On
// [RL2] Installer keeps bank two positions 1-5 Off
// [RL3] Bank two positions 6,7 select clock source
// [RL4] Plug-and-play starts with recovered clocking
// [RL5] Bank two position 8 gates terminal loop requests
// [RL6] Rate switches binary, Off one, minus two
// [RL7] Bad rate at power-up blinks error every 200ms
// [RL8] Line rate follows terminal rate
// [RL9] Bank three position 7 Off requests defaults reset
// [RL10] Position 8 On: sample data on falling edge
// [RL11] Position 8 Off: sample data on rising edge
// [RL12] Factory defaults: 64k, normal, normal
// [RL13] Operator sets all switches On for download
// [RL14] All On: plug-and-play, far end configures
// [RL15] Far end sets rate; premises unit adopts
// [RL16] Plug-and-play: all else takes default
// [RL17] Far end uses internal or terminal clocking
// [RL18] Switches sampled after reset, then held
module dswcfg_decoder #(
    parameter int BLINK_PERIOD_CYC = dswcfg_pkg::BLINK_PERIOD_CYC,
    parameter int BLINK_ON_CYC = dswcfg_pkg::BLINK_PERIOD_CYC / 2,
    parameter int SETTLE_CYC = dswcfg_pkg::SETTLE_CYC
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic tx_clk,
    input wire logic [dswcfg_pkg::SW_BITS-1:0] reserved_switch_bank,
    input wire logic [dswcfg_pkg::SW_BITS-1:0] clocking_loop_switch_bank,
    input wire logic [dswcfg_pkg::SW_BITS-1:0] rate_switch_bank,
    input wire logic loop_request,
    input wire logic transmit_data_in,
    input wire logic far_rate_stb,
    input wire logic [dswcfg_pkg::RATE_W-1:0] far_rate_val,
    output dswcfg_pkg::dswcfg_clk_src_t clock_source,
    output logic clock_mode_reserved,
    output logic loop_enable,
    output logic loopback_start,
    output logic [dswcfg_pkg::MULT_W-1:0] terminal_rate_mult,
    output logic [dswcfg_pkg::MULT_W-1:0] line_rate_sel,
    output logic sw_defaults_reset,
    output logic sample_rising,
    output logic plug_and_play,
    output logic code_download_mode,
    output logic config_valid,
    output logic error_indicator,
    output logic td_sample
);

    localparam int BLINK_W = $clog2(BLINK_PERIOD_CYC + 1);
    localparam int SETTLE_W = $clog2(SETTLE_CYC + 1);
    localparam logic [BLINK_W-1:0] BLINK_LAST = BLINK_W'(BLINK_PERIOD_CYC - 1);
    localparam logic [BLINK_W-1:0] BLINK_ON = BLINK_W'(BLINK_ON_CYC);
    localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(SETTLE_CYC - 1);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [dswcfg_pkg::SW_BITS-1:0] b1_s1_q, b1_s2_q, b2_s1_q, b2_s2_q, b3_s1_q, b3_s2_q;
    logic loop_s1_q, loop_s2_q;

    // Two flip-flops on every switch and the loop request pin
    always_ff @(posedge clk)
    begin
        b1_s1_q <= reserved_switch_bank;
        b1_s2_q <= b1_s1_q;
        b2_s1_q <= clocking_loop_switch_bank;
        b2_s2_q <= b2_s1_q;
        b3_s1_q <= rate_switch_bank;
        b3_s2_q <= b3_s1_q;
        loop_s1_q <= loop_request;
        loop_s2_q <= loop_s1_q;
    end

    // ------------------------------------------------------------------
    // Switch decode of the synchronised banks
    // ------------------------------------------------------------------
    logic all_on;
    logic [dswcfg_pkg::RATE_W-1:0] raw_rate;
    logic raw_ok;
    logic [dswcfg_pkg::RATE_W-1:0] raw_mult;

    // Everything On means plug-and-play and download mode
    assign all_on = (b1_s2_q == dswcfg_pkg::ALL_ON) && (b2_s2_q == dswcfg_pkg::ALL_ON)
                    && (b3_s2_q == dswcfg_pkg::ALL_ON); // RL14
    assign raw_rate = dswcfg_pkg::rate_raw(b3_s2_q[dswcfg_pkg::RATE_W-1:0]); // RL6
    assign raw_ok = dswcfg_pkg::rate_ok(raw_rate);
    assign raw_mult = raw_rate - dswcfg_pkg::RATE_OFFSET; // RL6

    // ------------------------------------------------------------------
    // Power-up sequencing
    // ------------------------------------------------------------------
    dswcfg_pkg::dswcfg_state_t state_q;
    logic [SETTLE_W-1:0] settle_cnt_q;
    logic settle_done;

    assign settle_done = (state_q == dswcfg_pkg::ST_SETTLE) && (settle_cnt_q == SETTLE_LAST);

    // Let the synchronised switches settle before the one-time sample
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            settle_cnt_q <= '0;
        else if (state_q == dswcfg_pkg::ST_SETTLE && !settle_done)
            settle_cnt_q <= settle_cnt_q + 1'h1;
    end

    // Sample once, then run or report a bad rate until the next reset
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            state_q <= dswcfg_pkg::ST_SETTLE;
        else
        begin
            case (state_q)
                dswcfg_pkg::ST_SETTLE:
                begin
                    if (settle_done)
                        state_q <= (all_on || raw_ok) ? dswcfg_pkg::ST_RUN : dswcfg_pkg::ST_RATE_ERR; // RL7
                end
                dswcfg_pkg::ST_RUN:
                    state_q <= dswcfg_pkg::ST_RUN; // RL18
                dswcfg_pkg::ST_RATE_ERR:
                    state_q <= dswcfg_pkg::ST_RATE_ERR;
                default:
                    state_q <= dswcfg_pkg::ST_SETTLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Latched configuration
    // ------------------------------------------------------------------
    dswcfg_pkg::dswcfg_clk_src_t clk_src_q;
    logic clk_rsvd_q, loop_en_q, swdef_q, rising_q, pnp_q;
    logic [dswcfg_pkg::MULT_W-1:0] rate_q;

    // Clocking, loop, defaults and sampling held from the one-time sample
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            clk_src_q <= dswcfg_pkg::CLK_RECOVERED;
            clk_rsvd_q <= 1'h0;
            loop_en_q <= 1'h0;
            swdef_q <= 1'h0; // RL12
            rising_q <= 1'h0; // RL12
            pnp_q <= 1'h0;
        end
        else if (settle_done)
        begin
            pnp_q <= all_on; // RL14
            if (all_on)
            begin
                clk_src_q <= dswcfg_pkg::CLK_RECOVERED; // RL4
                clk_rsvd_q <= 1'h0; // RL16
                loop_en_q <= 1'h0; // RL16
                swdef_q <= 1'h0; // RL16
                rising_q <= 1'h0; // RL16
            end
            else
            begin
                clk_src_q <= dswcfg_pkg::clk_decode(b2_s2_q[dswcfg_pkg::CLK_POS_A],
                                                    b2_s2_q[dswcfg_pkg::CLK_POS_B]); // RL3
                clk_rsvd_q <= (b2_s2_q[dswcfg_pkg::CLK_POS_A] == dswcfg_pkg::SW_OFF)
                              && (b2_s2_q[dswcfg_pkg::CLK_POS_B] == dswcfg_pkg::SW_OFF); // RL3
                loop_en_q <= (b2_s2_q[dswcfg_pkg::LOOP_POS] == dswcfg_pkg::SW_ON); // RL5
                swdef_q <= (b3_s2_q[dswcfg_pkg::SWDEF_POS] == dswcfg_pkg::SW_OFF); // RL9
                rising_q <= (b3_s2_q[dswcfg_pkg::SAMPLE_POS] == dswcfg_pkg::SW_OFF); // RL11
            end
        end
    end

    // ------------------------------------------------------------------
    // Far-end rate crossing
    // ------------------------------------------------------------------
    logic [dswcfg_pkg::RATE_W-1:0] far_hold;
    logic far_toggle, far_s1_q, far_s2_q, far_s3_q, far_load;

    // Toggle synchroniser; hold word is stable when the toggle arrives
    always_ff @(posedge clk)
    begin
        far_s1_q <= far_toggle;
        far_s2_q <= far_s1_q;
        far_s3_q <= far_s2_q;
    end

    assign far_load = far_s2_q ^ far_s3_q;

    // Terminal rate: from switches at sample time, or from the far end
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            rate_q <= dswcfg_pkg::DEFAULT_RATE_MULT; // RL12
        else if (settle_done)
            rate_q <= (all_on || !raw_ok) ? dswcfg_pkg::DEFAULT_RATE_MULT
                                          : raw_mult[dswcfg_pkg::MULT_W-1:0]; // RL6
        else if (far_load && pnp_q && dswcfg_pkg::rate_ok(far_hold + dswcfg_pkg::RATE_OFFSET))
            rate_q <= far_hold[dswcfg_pkg::MULT_W-1:0]; // RL15
    end

    // ------------------------------------------------------------------
    // Error indicator blink
    // ------------------------------------------------------------------
    logic [BLINK_W-1:0] blink_cnt_q;
    logic err_q;

    // Free-running period counter while the rate fault stands
    always_ff @(posedge clk)
    begin
        if (sys_rst || state_q != dswcfg_pkg::ST_RATE_ERR)
            blink_cnt_q <= '0;
        else if (blink_cnt_q == BLINK_LAST)
            blink_cnt_q <= '0;
        else
            blink_cnt_q <= blink_cnt_q + 1'h1;
    end

    // One flash at the start of each period
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            err_q <= 1'h0;
        else
            err_q <= (state_q == dswcfg_pkg::ST_RATE_ERR) && (blink_cnt_q == BLINK_LAST || blink_cnt_q < BLINK_ON - 1'h1); // RL7
    end

    // ------------------------------------------------------------------
    // Link-side instance
    // ------------------------------------------------------------------
    dswcfg_link_side u_link (
        .tx_clk(tx_clk),
        .sys_rst(sys_rst),
        .sample_rising(rising_q),
        .transmit_data_in(transmit_data_in),
        .far_rate_stb(far_rate_stb),
        .far_rate_val(far_rate_val),
        .td_sample(td_sample),
        .far_hold(far_hold),
        .far_toggle(far_toggle)
    );

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign clock_source = clk_src_q;
    assign clock_mode_reserved = clk_rsvd_q;
    assign loop_enable = loop_en_q;
    assign loopback_start = loop_en_q && loop_s2_q && (state_q == dswcfg_pkg::ST_RUN); // RL5
    assign terminal_rate_mult = rate_q;
    assign line_rate_sel = rate_q; // RL8
    assign sw_defaults_reset = swdef_q;
    assign sample_rising = rising_q;
    assign plug_and_play = pnp_q;
    assign code_download_mode = pnp_q; // RL13
    assign config_valid = (state_q == dswcfg_pkg::ST_RUN);
    assign error_indicator = err_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_clock_decode: // RL3
    assert property (@(posedge clk) disable iff (sys_rst)
        settle_done && !all_on |=> clk_src_q == dswcfg_pkg::clk_decode(
            $past(b2_s2_q[dswcfg_pkg::CLK_POS_A]), $past(b2_s2_q[dswcfg_pkg::CLK_POS_B])))
        else $error("Clock source does not match bank two");

    a_pnp_defaults: // RL16
    assert property (@(posedge clk) disable iff (sys_rst)
        pnp_q |-> clk_src_q == dswcfg_pkg::CLK_RECOVERED && !loop_en_q && !swdef_q && !rising_q)
        else $error("Plug-and-play settings not at default");

    a_loop_gate: // RL5
    assert property (@(posedge clk) disable iff (sys_rst)
        loopback_start |-> loop_en_q && loop_s2_q)
        else $error("Loopback started while disabled");

    a_rate_decode: // RL6
    assert property (@(posedge clk) disable iff (sys_rst)
        settle_done && !all_on && raw_ok |=> rate_q == $past(raw_mult[dswcfg_pkg::MULT_W-1:0]))
        else $error("Terminal rate decode wrong");

    a_bad_rate_error: // RL7
    assert property (@(posedge clk) disable iff (sys_rst)
        settle_done && !all_on && !raw_ok |=> state_q == dswcfg_pkg::ST_RATE_ERR ##1 err_q)
        else $error("Bad rate did not raise error blink");

    a_blink_restart: // RL7
    assert property (@(posedge clk) disable iff (sys_rst)
        state_q == dswcfg_pkg::ST_RATE_ERR && blink_cnt_q == BLINK_LAST |=> err_q && blink_cnt_q == '0)
        else $error("Blink period not restarted");

    a_config_held: // RL18
    assert property (@(posedge clk) disable iff (sys_rst)
        config_valid && $past(config_valid) && !$past(far_load) |-> $stable(rate_q) && $stable(clk_src_q))
        else $error("Configuration changed while running");

    a_far_adopt: // RL15
    assert property (@(posedge clk) disable iff (sys_rst)
        far_load && pnp_q && !settle_done && dswcfg_pkg::rate_ok(far_hold + dswcfg_pkg::RATE_OFFSET)
        |=> rate_q == $past(far_hold[dswcfg_pkg::MULT_W-1:0]))
        else $error("Far-end rate not adopted");

    a_sw_rate_ignored: // RL14
    assert property (@(posedge clk) disable iff (sys_rst)
        far_load && !pnp_q && config_valid |=> $stable(rate_q))
        else $error("Far-end rate taken outside plug-and-play");

endmodule

// file: core/dswcfg_link_side.sv
// Link-clock side: transmit data sampling and far-end rate capture.
// Assumes tx_clk is the transmit clock supplied to the terminal and that
// the far end spaces rate strobes by at least eight tx_clk cycles.
module dswcfg_link_side (
    input wire logic tx_clk,
    input wire logic sys_rst,
    input wire logic sample_rising,
    input wire logic transmit_data_in,
    input wire logic far_rate_stb,
    input wire logic [dswcfg_pkg::RATE_W-1:0] far_rate_val,
    output logic td_sample,
    output logic [dswcfg_pkg::RATE_W-1:0] far_hold,
    output logic far_toggle
);

    // ------------------------------------------------------------------
    // Crossings into the link domain
    // ------------------------------------------------------------------
    logic rst_s1_q, rst_s2_q, inv_s1_q, inv_s2_q;
    logic td_fall_q, td_rise_q, td_sample_q, far_toggle_q;
    logic [dswcfg_pkg::RATE_W-1:0] far_hold_q;

    // Two-stage synchronisers for reset and the sampling choice
    always_ff @(posedge tx_clk)
    begin
        rst_s1_q <= sys_rst;
        rst_s2_q <= rst_s1_q;
        inv_s1_q <= sample_rising;
        inv_s2_q <= inv_s1_q;
    end

    // ------------------------------------------------------------------
    // Transmit data sampling
    // ------------------------------------------------------------------
    // Falling-edge capture
    always_ff @(negedge tx_clk)
    begin
        td_fall_q <= transmit_data_in; // RL10
    end

    // Rising-edge capture
    always_ff @(posedge tx_clk)
    begin
        td_rise_q <= transmit_data_in; // RL11
    end

    // Pick the configured edge, retimed to the rising edge
    always_ff @(posedge tx_clk)
    begin
        if (rst_s2_q)
            td_sample_q <= 1'h0;
        else if (inv_s2_q)
            td_sample_q <= td_rise_q; // RL11
        else
            td_sample_q <= td_fall_q; // RL10
    end

    // ------------------------------------------------------------------
    // Far-end rate capture, handed over by toggle
    // ------------------------------------------------------------------
    always_ff @(posedge tx_clk)
    begin
        if (rst_s2_q)
        begin
            far_hold_q <= '0;
            far_toggle_q <= 1'h0;
        end
        else if (far_rate_stb)
        begin
            far_hold_q <= far_rate_val; // RL15
            far_toggle_q <= ~far_toggle_q;
        end
    end

    assign td_sample = td_sample_q;
    assign far_hold = far_hold_q;
    assign far_toggle = far_toggle_q;

endmodule

// file: core/dswcfg_pkg.sv
// Constants, types and decode functions for the switch configuration decoder.
// Assumes switch inputs read 1 for On and 0 for Off.
package dswcfg_pkg;

    // ------------------------------------------------------------------
    // Switch field layout
    // ------------------------------------------------------------------
    localparam int SW_BITS = 8;
    localparam int CLK_POS_A = 5;       // Bank two position 6
    localparam int CLK_POS_B = 6;       // Bank two position 7
    localparam int LOOP_POS = 7;        // Bank two position 8
    localparam int RATE_W = 6;          // Bank three positions 1 to 6
    localparam int SWDEF_POS = 6;       // Bank three position 7
    localparam int SAMPLE_POS = 7;      // Bank three position 8
    localparam logic SW_ON = 1'h1;
    localparam logic SW_OFF = 1'h0;
    localparam logic [SW_BITS-1:0] ALL_ON = 8'hff;

    // ------------------------------------------------------------------
    // Rate encoding
    // ------------------------------------------------------------------
    localparam int MULT_W = 5;
    localparam logic [RATE_W-1:0] RATE_OFFSET = 6'h02;
    localparam logic [RATE_W-1:0] RATE_MULT_MIN = 6'h01;  // 64 kbps
    localparam logic [RATE_W-1:0] RATE_MULT_MAX = 6'h12;  // 1152 kbps
    localparam logic [MULT_W-1:0] DEFAULT_RATE_MULT = 5'h01;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ = 100_000_000;
    localparam int BLINK_PERIOD_MS = 200;
    localparam int BLINK_PERIOD_CYC = (CLK_HZ / 1000) * BLINK_PERIOD_MS;
    localparam int SETTLE_US = 10;
    localparam int SETTLE_CYC = (CLK_HZ / 1_000_000) * SETTLE_US;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        CLK_INTERNAL = 2'h0,
        CLK_TERMINAL = 2'h1,
        CLK_RECOVERED = 2'h2
    } dswcfg_clk_src_t;

    typedef enum logic [1:0] {
        ST_SETTLE = 2'h0,
        ST_RUN = 2'h1,
        ST_RATE_ERR = 2'h2
    } dswcfg_state_t;

    // Binary value of the rate switches, Off counting as one
    function automatic logic [RATE_W-1:0] rate_raw(input logic [RATE_W-1:0] sw);
        rate_raw = ~sw;
    endfunction

    // A raw value is usable when it maps onto 1 to 18 multiples of 64 kbps
    function automatic logic rate_ok(input logic [RATE_W-1:0] raw);
        rate_ok = (raw >= RATE_MULT_MIN + RATE_OFFSET) && (raw <= RATE_MULT_MAX + RATE_OFFSET);
    endfunction

    // Clock source from bank two positions 6 and 7
    function automatic dswcfg_clk_src_t clk_decode(input logic a, input logic b);
        if (a == SW_ON && b == SW_ON)
            clk_decode = CLK_INTERNAL;
        else if (a == SW_OFF && b == SW_ON)
            clk_decode = CLK_TERMINAL;
        else if (a == SW_ON && b == SW_OFF)
            clk_decode = CLK_RECOVERED;
        else
            clk_decode = CLK_INTERNAL;
    endfunction

endpackage

// file: testbench/dswcfg_far_end.sv
// Far-end model: the central-office unit and the terminal transmit data.
// Assumes tx_clk runs free from the bench and the decoder samples on it.
module dswcfg_far_end (
    input wire logic tx_clk,
    output logic far_rate_stb,
    output logic [dswcfg_pkg::RATE_W-1:0] far_rate_val,
    output logic transmit_data_in
);
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------------
    // Terminal data
    // ------------------------------------------------------------------
    // High only around the falling edge, low around the rising edge
    initial transmit_data_in = 1'b0;
    always @(posedge tx_clk)
    begin
        #16 transmit_data_in = 1'b1;
        #32 transmit_data_in = 1'b0;
    end

    // ------------------------------------------------------------------
    // Rate messages
    // ------------------------------------------------------------------
    // Idle strobe low and a word that is no longer valid
    initial
    begin
        far_rate_stb = 1'b0;
        far_rate_val = 6'h00;
    end

    // One strobe, then the word turns over and eight cycles pass
    task automatic send_rate(input logic [dswcfg_pkg::RATE_W-1:0] val);
        @(posedge tx_clk);
        #1;
        far_rate_stb = 1'b1;
        far_rate_val = val;
        @(posedge tx_clk);
        #1;
        far_rate_stb = 1'b0;
        far_rate_val = ~val;
        repeat (8) @(posedge tx_clk);
    endtask
endmodule

// file: testbench/tb.sv
// Self-checking bench for the switch configuration decoder.
// Assumes short settle and blink counts set by parameters below.
module tb;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct {
        logic [7:0] b2;
        logic [7:0] b3;
        dswcfg_pkg::dswcfg_clk_src_t src;
        logic rsv;
        logic loop;
        logic [4:0] rate;
        logic swdef;
        logic rise;
    } dswcfg_case_t;

    logic clk, tx_clk, sys_rst, loop_request, far_rate_stb, transmit_data_in;
    logic [7:0] reserved_switch_bank, clocking_loop_switch_bank, rate_switch_bank, cnt;
    logic [5:0] far_rate_val;
    dswcfg_pkg::dswcfg_clk_src_t clock_source;
    logic clock_mode_reserved, loop_enable, loopback_start, sw_defaults_reset, sample_rising;
    logic plug_and_play, code_download_mode, config_valid, error_indicator, td_sample;
    logic [4:0] terminal_rate_mult, line_rate_sel;
    int fails = 0;
    int comparisons = 0;
    dswcfg_case_t cases [4];
    dswcfg_case_t pnp_def;

    // ------------------------------------------------------------------
    // Clocks and instances
    // ------------------------------------------------------------------
    // System clock, 10 ns period
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Transmit clock from an internally clocked far end, 64 ns period
    initial
    begin
        tx_clk = 1'b0;
        #3;
        forever #32 tx_clk = ~tx_clk;
    end

    dswcfg_decoder #(.BLINK_PERIOD_CYC(40), .BLINK_ON_CYC(20), .SETTLE_CYC(4)) i_dswcfg_decoder (
        .clk(clk), .sys_rst(sys_rst), .tx_clk(tx_clk), .reserved_switch_bank(reserved_switch_bank),
        .clocking_loop_switch_bank(clocking_loop_switch_bank), .rate_switch_bank(rate_switch_bank),
        .loop_request(loop_request), .transmit_data_in(transmit_data_in), .far_rate_stb(far_rate_stb),
        .far_rate_val(far_rate_val), .clock_source(clock_source), .clock_mode_reserved(clock_mode_reserved),
        .loop_enable(loop_enable), .loopback_start(loopback_start), .terminal_rate_mult(terminal_rate_mult),
        .line_rate_sel(line_rate_sel), .sw_defaults_reset(sw_defaults_reset), .sample_rising(sample_rising),
        .plug_and_play(plug_and_play), .code_download_mode(code_download_mode), .config_valid(config_valid),
        .error_indicator(error_indicator), .td_sample(td_sample));

    dswcfg_far_end i_dswcfg_far_end (.tx_clk(tx_clk), .far_rate_stb(far_rate_stb),
        .far_rate_val(far_rate_val), .transmit_data_in(transmit_data_in));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    // Value compare, counted
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
        comparisons++;
        if (seen !== exp)
        begin
            $display("unexpected %s expected %h seen %h", name, exp, seen);
            fails++;
        end
    endtask

    // Verdict and end of run
    task automatic give_verdict;
        if (fails == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Set switches, reset long enough for both clocks, let settle finish
    task automatic power_up(input logic [7:0] b1, input logic [7:0] b2, input logic [7:0] b3);
        @(negedge clk);
        sys_rst = 1'b1;
        reserved_switch_bank = b1;
        clocking_loop_switch_bank = b2;
        rate_switch_bank = b3;
        repeat (30) @(negedge clk);
        sys_rst = 1'b0;
        repeat (10) @(negedge clk);
    endtask

    // Whole decoded configuration against one expected set
    task automatic check_cfg(input dswcfg_case_t c, input logic pnp);
        chk("clock_source", {6'h00, c.src}, {6'h00, clock_source});
        chk("clock_mode_reserved", {7'h00, c.rsv}, {7'h00, clock_mode_reserved});
        chk("loop_enable", {7'h00, c.loop}, {7'h00, loop_enable});
        chk("terminal_rate_mult", {3'h0, c.rate}, {3'h0, terminal_rate_mult});
        chk("line_rate_sel", {3'h0, c.rate}, {3'h0, line_rate_sel});
        chk("sw_defaults_reset", {7'h00, c.swdef}, {7'h00, sw_defaults_reset});
        chk("sample_rising", {7'h00, c.rise}, {7'h00, sample_rising});
        chk("plug_and_play", {7'h00, pnp}, {7'h00, plug_and_play});
        chk("code_download_mode", {7'h00, pnp}, {7'h00, code_download_mode});
        chk("config_valid", 8'h01, {7'h00, config_valid});
        chk("error_indicator", 8'h00, {7'h00, error_indicator});
    endtask

    // Wait a bounded time for a far-end rate to land, then compare
    task automatic wait_rate(input logic [4:0] exp);
        @(negedge clk);
        for (int k = 0; k < 40 && terminal_rate_mult !== exp; k++)
            @(negedge clk);
        chk("terminal_rate_mult", {3'h0, exp}, {3'h0, terminal_rate_mult});
        chk("line_rate_sel", {3'h0, exp}, {3'h0, line_rate_sel});
    endtask

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    // Main sequence
    initial
    begin
        sys_rst = 1'b1;
        loop_request = 1'b0;
        reserved_switch_bank = 8'hff;
        clocking_loop_switch_bank = 8'h20;
        rate_switch_bank = 8'hfc;
        cases[0] = '{8'h20, 8'hfc, dswcfg_pkg::CLK_RECOVERED, 1'b0, 1'b0, 5'h01, 1'b0, 1'b0};
        cases[1] = '{8'he0, 8'h2b, dswcfg_pkg::CLK_INTERNAL, 1'b0, 1'b1, 5'h12, 1'b1, 1'b1};
        cases[2] = '{8'h40, 8'hf8, dswcfg_pkg::CLK_TERMINAL, 1'b0, 1'b0, 5'h05, 1'b0, 1'b0};
        cases[3] = '{8'h00, 8'h7c, dswcfg_pkg::CLK_INTERNAL, 1'b1, 1'b0, 5'h01, 1'b0, 1'b1};
        pnp_def = '{8'hff, 8'hff, dswcfg_pkg::CLK_RECOVERED, 1'b0, 1'b0, 5'h01, 1'b0, 1'b0};
        // Switch settings, loop requests, data edge, ignored late changes
        foreach (cases[i])
        begin
            power_up(8'hff, cases[i].b2, cases[i].b3);
            check_cfg(cases[i], 1'b0);
            repeat (3) @(posedge tx_clk);
            @(negedge clk);
            chk("td_sample", {7'h00, ~cases[i].rise}, {7'h00, td_sample});
            loop_request = 1'b1;
            repeat (4) @(negedge clk);
            chk("loopback_start", {7'h00, cases[i].loop}, {7'h00, loopback_start});
            loop_request = 1'b0;
            rate_switch_bank = 8'hfd;
            i_dswcfg_far_end.send_rate(6'h09);
            @(negedge clk);
            chk("loopback_start", 8'h00, {7'h00, loopback_start});
            check_cfg(cases[i], 1'b0);
        end
        // Unsupported rates below and above the range, and an all-On set
        // spoilt by bank one, blink the indicator
        for (int j = 0; j < 3; j++)
        begin
            power_up((j == 2) ? 8'h00 : 8'hff, (j == 2) ? 8'hff : 8'h20,
                     (j == 0) ? 8'hfd : (j == 1) ? 8'hea : 8'hff);
            chk("config_valid", 8'h00, {7'h00, config_valid});
            chk("plug_and_play", 8'h00, {7'h00, plug_and_play});
            cnt = 8'h00;
            repeat (40)
            begin
                @(negedge clk);
                cnt = cnt + {7'h00, error_indicator};
            end
            chk("error_indicator", 8'h14, cnt);
        end
        // All switches On: defaults, then rate from the far end
        power_up(8'hff, 8'hff, 8'hff);
        check_cfg(pnp_def, 1'b1);
        rate_switch_bank = 8'h00;
        i_dswcfg_far_end.send_rate(6'h12);
        wait_rate(5'h12);
        i_dswcfg_far_end.send_rate(6'h00);
        i_dswcfg_far_end.send_rate(6'h13);
        wait_rate(5'h12);
        i_dswcfg_far_end.send_rate(6'h01);
        wait_rate(5'h01);
        pnp_def.rate = 5'h01;
        check_cfg(pnp_def, 1'b1);
        give_verdict;
    end

    // Watchdog
    initial
    begin
        repeat (20000) @(posedge clk);
        fails++;
        give_verdict;
    end
endmodule
